/* include/cwseq_pkg.sv */
//----------------------------------------------------------------------------
// Purpose: Constants and types of the control write sequencer
// Assumes: 16-bit control registers, 8-bit register addresses
// Notes:   Offsets are the host register addresses of the sequencer
//----------------------------------------------------------------------------
package cwseq_pkg;

  // ************************************************************
  // Register offsets
  // ************************************************************
  localparam logic [7:0] CWSEQ_OFS_CTRL    = 8'h46;
  localparam logic [7:0] CWSEQ_OFS_TARGET  = 8'h47;
  localparam logic [7:0] CWSEQ_OFS_PAYLOAD = 8'h48;
  localparam logic [7:0] CWSEQ_OFS_LAUNCH  = 8'h49;
  localparam logic [7:0] CWSEQ_OFS_STATUS  = 8'h4a;
  localparam logic [7:0] CWSEQ_OFS_CURRENT = 8'h4b;

  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int CWSEQ_ON_BIT     = 8;
  localparam int CWSEQ_WIDTH_LSB  = 12;
  localparam int CWSEQ_FLSB_LSB   = 8;
  localparam int CWSEQ_LAST_BIT   = 14;
  localparam int CWSEQ_DELAY_LSB  = 8;
  localparam int CWSEQ_LAUNCH_BIT = 8;
  localparam int CWSEQ_CANCEL_BIT = 9;
  localparam int CWSEQ_RUN_BIT    = 0;

  // ************************************************************
  // Reset values and limits
  // ************************************************************
  localparam logic [3:0] CWSEQ_RST_LOAD_IDX = 4'h0;
  localparam logic [5:0] CWSEQ_RST_FIRST    = 6'h00;
  localparam logic [5:0] CWSEQ_RAM_LAST     = 6'h0f;
  localparam logic [5:0] CWSEQ_ROM_LAST     = 6'h3a;
  localparam int         CWSEQ_RAM_DEPTH    = 16;

  // ************************************************************
  // Timing
  // ************************************************************
  localparam int          CWSEQ_CLK_PERIOD_NS = 10;
  localparam int          CWSEQ_TICK_NS       = 62500;
  localparam int          CWSEQ_TICK_CYCLES   = CWSEQ_TICK_NS / CWSEQ_CLK_PERIOD_NS;
  localparam logic [15:0] CWSEQ_TICK_BASE     = 16'h0008;

  // ************************************************************
  // Types
  // ************************************************************
  typedef struct packed {
    logic [2:0] width;
    logic [3:0] flsb;
    logic [7:0] addr;
    logic       last;
    logic [3:0] delay;
    logic [7:0] value;
  } cwseq_step_s;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [15:0] data;
  } cwseq_bus_s;

  typedef enum logic [1:0] {
    CWSEQ_IDLE,
    CWSEQ_FETCH,
    CWSEQ_MODIFY,
    CWSEQ_WAIT
  } cwseq_state_e;

endpackage

/* logic/cwseq_top.sv */
//----------------------------------------------------------------------------
// Purpose: Control write sequencer with 16-step RAM and step timer
// Assumes: Host port and control register port are on mclk_in
// Notes:   Host read data follows the read strobe by one cycle; control read data is taken in the strobe cycle
//----------------------------------------------------------------------------
`timescale 1ns/1ns
module cwseq_top
  import cwseq_pkg::*;
#(
  parameter int TICK_CYCLES = CWSEQ_TICK_CYCLES
) (
  input  wire logic        mclk_in,
  input  wire logic        srst_in,
  input  wire logic        host_wr_in,
  input  wire logic        host_rd_in,
  input  wire logic [7:0]  host_addr_in,
  input  wire logic [15:0] host_wdata_in,
  output logic      [15:0] host_rdata_out,
  output logic             host_lock_out,
  output logic             ctl_wr_out,
  output logic             ctl_rd_out,
  output logic      [7:0]  ctl_addr_out,
  output logic      [15:0] ctl_wdata_out,
  input  wire logic [15:0] ctl_rdata_in
);

  if (TICK_CYCLES < 2 || TICK_CYCLES > 65535) begin : g_tick_check
    $error("TICK_CYCLES out of range");
  end

  // ************************************************************
  // Helper functions
  // ************************************************************
  function automatic logic [15:0] field_mask(input logic [2:0] w, input logic [3:0] l);
    logic [15:0] m;
    m = 16'h00ff >> (3'h7 - w);
    return m << l;
  endfunction

  function automatic logic [15:0] field_data(input cwseq_step_s s);
    logic [15:0] d;
    d = {8'h00, s.value} & (16'h00ff >> (3'h7 - s.width));
    return d << s.flsb;
  endfunction

  // ************************************************************
  // State
  // ************************************************************
  cwseq_step_s  mem_r [CWSEQ_RAM_DEPTH];
  cwseq_step_s  mem_nxt [CWSEQ_RAM_DEPTH];
  cwseq_step_s  step_r, step_nxt;
  cwseq_state_e state_r, state_nxt;
  cwseq_bus_s   ctl_r, ctl_nxt;
  logic         on_r, on_nxt;
  logic [3:0]   load_idx_r, load_idx_nxt;
  logic [5:0]   first_r, first_nxt;
  logic         launch_r, launch_nxt;
  logic         run_r, run_nxt;
  logic [5:0]   cur_r, cur_nxt;
  logic [15:0]  rdata_r, rdata_nxt;
  logic [15:0]  div_r, div_nxt;
  logic [15:0]  ticks_r, ticks_nxt;
  logic         rom_r, rom_nxt;

  logic        wr_ok;
  logic [15:0] step_ticks;
  logic        step_end;
  cwseq_step_s sel;

  // ************************************************************
  // Next state
  // ************************************************************
  always_comb begin
    mem_nxt      = mem_r;
    step_nxt     = step_r;
    state_nxt    = state_r;
    ctl_nxt      = '0;
    on_nxt       = on_r;
    load_idx_nxt = load_idx_r;
    first_nxt    = first_r;
    launch_nxt   = launch_r;
    run_nxt      = run_r;
    cur_nxt      = cur_r;
    rdata_nxt    = rdata_r;
    div_nxt      = div_r;
    ticks_nxt    = ticks_r;
    rom_nxt      = rom_r;
    sel          = mem_r[load_idx_r];
    wr_ok        = host_wr_in && !run_r;
    step_ticks   = (16'h0001 << step_r.delay) + CWSEQ_TICK_BASE;
    step_end     = (ticks_r == step_ticks - 16'h0001) &&
                   (div_r == 16'(TICK_CYCLES - 1));

    // Host register reads
    if (host_rd_in) begin
      case (host_addr_in)
        CWSEQ_OFS_CTRL: begin
          rdata_nxt = {7'h00, on_r, 4'h0, load_idx_r};
        end
        CWSEQ_OFS_TARGET: begin
          rdata_nxt = {1'b0, sel.width, sel.flsb, sel.addr};
        end
        CWSEQ_OFS_PAYLOAD: begin
          rdata_nxt = {1'b0, sel.last, 2'b00, sel.delay, sel.value};
        end
        CWSEQ_OFS_LAUNCH: begin
          rdata_nxt = {7'h00, launch_r, 2'b00, first_r};
        end
        CWSEQ_OFS_STATUS: begin
          rdata_nxt = {15'h0000, run_r};
        end
        CWSEQ_OFS_CURRENT: begin
          rdata_nxt = {10'h000, cur_r};
        end
        default: begin
          rdata_nxt = 16'h0000;
        end
      endcase
    end

    // Host register writes
    if (wr_ok) begin
      case (host_addr_in)
        CWSEQ_OFS_CTRL: begin
          on_nxt       = host_wdata_in[CWSEQ_ON_BIT];
          load_idx_nxt = host_wdata_in[3:0];
        end
        CWSEQ_OFS_TARGET: begin
          mem_nxt[load_idx_r].width = host_wdata_in[CWSEQ_WIDTH_LSB +: 3];
          mem_nxt[load_idx_r].flsb  = host_wdata_in[CWSEQ_FLSB_LSB +: 4];
          mem_nxt[load_idx_r].addr  = host_wdata_in[7:0];
        end
        CWSEQ_OFS_PAYLOAD: begin
          mem_nxt[load_idx_r].last  = host_wdata_in[CWSEQ_LAST_BIT];
          mem_nxt[load_idx_r].delay = host_wdata_in[CWSEQ_DELAY_LSB +: 4];
          mem_nxt[load_idx_r].value = host_wdata_in[7:0];
        end
        CWSEQ_OFS_LAUNCH: begin
          first_nxt = host_wdata_in[5:0];
          if (host_wdata_in[CWSEQ_LAUNCH_BIT] && on_r) begin
            launch_nxt = 1'b1;
          end
        end
        default: begin
        end
      endcase
    end

    // Timer runs while a step is active
    if (state_r != CWSEQ_IDLE) begin
      if (div_r == 16'(TICK_CYCLES - 1)) begin
        div_nxt   = 16'h0000;
        ticks_nxt = ticks_r + 16'h0001;
      end else begin
        div_nxt = div_r + 16'h0001;
      end
    end

    // Sequencer
    case (state_r)
      CWSEQ_IDLE: begin
        if (launch_r && on_r) begin
          if (first_r > CWSEQ_ROM_LAST) begin
            launch_nxt = 1'b0;
          end else begin
            run_nxt   = 1'b1;
            cur_nxt   = first_r;
            state_nxt = CWSEQ_FETCH;
          end
        end
      end
      CWSEQ_FETCH: begin
        div_nxt   = 16'h0001;
        ticks_nxt = 16'h0000;
        if (cur_r <= CWSEQ_RAM_LAST) begin
          step_nxt    = mem_r[cur_r[3:0]];
          rom_nxt     = 1'b0;
          ctl_nxt.rd  = 1'b1;
          ctl_nxt.addr = mem_r[cur_r[3:0]].addr;
        end else begin
          step_nxt      = '0;
          step_nxt.last = 1'b1;
          rom_nxt       = 1'b1;
        end
        state_nxt = CWSEQ_MODIFY;
      end
      CWSEQ_MODIFY: begin
        if (!rom_r) begin
          ctl_nxt.wr   = 1'b1;
          ctl_nxt.addr = step_r.addr;
          ctl_nxt.data = (ctl_rdata_in & ~field_mask(step_r.width, step_r.flsb)) |
                         field_data(step_r);
        end
        state_nxt = CWSEQ_WAIT;
      end
      CWSEQ_WAIT: begin
        if (step_end) begin
          if (step_r.last || cur_r == CWSEQ_ROM_LAST) begin
            run_nxt    = 1'b0;
            launch_nxt = 1'b0;
            state_nxt  = CWSEQ_IDLE;
          end else begin
            cur_nxt   = cur_r + 6'h01;
            state_nxt = CWSEQ_FETCH;
          end
        end
      end
      default: begin
        state_nxt = CWSEQ_IDLE;
      end
    endcase

    // Cancel is honoured even while running
    if (host_wr_in && host_addr_in == CWSEQ_OFS_LAUNCH &&
        host_wdata_in[CWSEQ_CANCEL_BIT]) begin
      state_nxt  = CWSEQ_IDLE;
      run_nxt    = 1'b0;
      launch_nxt = 1'b0;
      ctl_nxt    = '0;
    end

    if (!on_nxt && state_nxt == CWSEQ_IDLE) begin
      launch_nxt = 1'b0;
    end
  end

  // ************************************************************
  // Registers
  // ************************************************************
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      for (int i = 0; i < CWSEQ_RAM_DEPTH; i++) begin
        mem_r[i] <= '0;
      end
      step_r     <= '0;
      state_r    <= CWSEQ_IDLE;
      ctl_r      <= '0;
      on_r       <= 1'b0;
      load_idx_r <= CWSEQ_RST_LOAD_IDX;
      first_r    <= CWSEQ_RST_FIRST;
      launch_r   <= 1'b0;
      run_r      <= 1'b0;
      cur_r      <= 6'h00;
      rdata_r    <= 16'h0000;
      div_r      <= 16'h0000;
      ticks_r    <= 16'h0000;
      rom_r      <= 1'b0;
    end else begin
      mem_r      <= mem_nxt;
      step_r     <= step_nxt;
      state_r    <= state_nxt;
      ctl_r      <= ctl_nxt;
      on_r       <= on_nxt;
      load_idx_r <= load_idx_nxt;
      first_r    <= first_nxt;
      launch_r   <= launch_nxt;
      run_r      <= run_nxt;
      cur_r      <= cur_nxt;
      rdata_r    <= rdata_nxt;
      div_r      <= div_nxt;
      ticks_r    <= ticks_nxt;
      rom_r      <= rom_nxt;
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  assign host_rdata_out = rdata_r;
  assign host_lock_out  = run_r;
  assign ctl_wr_out     = ctl_r.wr;
  assign ctl_rd_out     = ctl_r.rd;
  assign ctl_addr_out   = ctl_r.addr;
  assign ctl_wdata_out  = ctl_r.data;

endmodule

/* tb/cwseq_properties.sv */
// Purpose: Port checks of the control write sequencer
// Assumes: Sees only the top module ports
// Notes:   Bound to every cwseq_top instance below
`timescale 1ns/1ns
module cwseq_checker
  import cwseq_pkg::*;
#(
  parameter int TICK_CYCLES = CWSEQ_TICK_CYCLES
) (
  input wire logic        mclk_in,
  input wire logic        srst_in,
  input wire logic        host_wr_in,
  input wire logic        host_rd_in,
  input wire logic [7:0]  host_addr_in,
  input wire logic [15:0] host_wdata_in,
  input wire logic [15:0] host_rdata_out,
  input wire logic        host_lock_out,
  input wire logic        ctl_wr_out,
  input wire logic        ctl_rd_out,
  input wire logic [7:0]  ctl_addr_out,
  input wire logic [15:0] ctl_wdata_out,
  input wire logic [15:0] ctl_rdata_in
);
  // ****************
  // Properties
  // ****************
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (srst_in);
  read_then_write_a: assert property (
    ctl_rd_out && !(host_wr_in && host_addr_in == CWSEQ_OFS_LAUNCH &&
    host_wdata_in[CWSEQ_CANCEL_BIT]) |=> ctl_wr_out && $stable(ctl_addr_out))
    else $error("no write after target read");
  write_has_read_a: assert property (ctl_wr_out |-> $past(ctl_rd_out))
    else $error("write without target read");
  access_busy_a: assert property (ctl_rd_out |-> host_lock_out)
    else $error("target access while idle");
  field_only_a: assert property (
    ctl_wr_out |-> $countones(ctl_wdata_out ^ ctl_rdata_in) <= 8)
    else $error("more than one field changed");
  step_gap_a: assert property (ctl_rd_out |=> !ctl_rd_out [*8])
    else $error("step too short");
  launch_cause_a: assert property ($rose(host_lock_out) |-> $past(host_wr_in, 2))
    else $error("run without launch write");
  cancel_stop_a: assert property (
    host_wr_in && host_addr_in == 8'h49 && host_wdata_in[9] |=> !host_lock_out ##1 !ctl_rd_out)
    else $error("cancel did not stop");
  rdata_hold_a: assert property (!$past(host_rd_in) |-> $stable(host_rdata_out))
    else $error("read data changed without read");
  cover property (ctl_wr_out);
  cover property ($fell(host_lock_out));
  cover property (host_wr_in && host_lock_out);
endmodule

bind cwseq_top cwseq_checker #(.TICK_CYCLES(TICK_CYCLES)) u_chk (
  .mclk_in, .srst_in, .host_wr_in, .host_rd_in, .host_addr_in, .host_wdata_in,
  .host_rdata_out, .host_lock_out, .ctl_wr_out, .ctl_rd_out, .ctl_addr_out,
  .ctl_wdata_out, .ctl_rdata_in);

/* tb/cwseq_ctl_model.sv */
// Purpose: Control registers written by the sequencer
// Assumes: Read data valid while a pulse is up
// Notes:   Idle bus shows inverted data
`timescale 1ns/1ns
module cwseq_ctl_model (
  input  wire logic        mclk_in,
  input  wire logic        ctl_wr_in,
  input  wire logic        ctl_rd_in,
  input  wire logic [7:0]  ctl_addr_in,
  input  wire logic [15:0] ctl_wdata_in,
  output logic      [15:0] ctl_rdata_out
);
  logic [15:0] mem [256] = '{default: 16'h0000};
  always @(posedge mclk_in) if (ctl_wr_in) mem[ctl_addr_in] <= ctl_wdata_in;
  assign ctl_rdata_out = (ctl_rd_in | ctl_wr_in) ? mem[ctl_addr_in] : ~mem[ctl_addr_in];
endmodule

/* tb/test_control_write_sequencer.sv */
// Purpose: Bench of the control write sequencer
// Assumes: Tick shortened to four cycles
// Notes:   Target registers live in the model
`timescale 1ns/1ns
module test_control_write_sequencer
  import cwseq_pkg::*;
;
  localparam int TK = 4;
  logic        mclk_in, srst_in, host_wr_in, host_rd_in, host_lock_out;
  logic        ctl_wr_out, ctl_rd_out;
  logic [7:0]  host_addr_in, ctl_addr_out;
  logic [15:0] host_wdata_in, host_rdata_out, ctl_wdata_out, ctl_rdata_in;
  int          n_errors, n_compared, n_wr, m, cyc;
  int          rd_t[$];

  cwseq_top #(.TICK_CYCLES(TK)) uut (
    .mclk_in, .srst_in, .host_wr_in, .host_rd_in, .host_addr_in, .host_wdata_in,
    .host_rdata_out, .host_lock_out, .ctl_wr_out, .ctl_rd_out, .ctl_addr_out,
    .ctl_wdata_out, .ctl_rdata_in);
  cwseq_ctl_model mdl (
    .mclk_in, .ctl_wr_in(ctl_wr_out), .ctl_rd_in(ctl_rd_out), .ctl_addr_in(ctl_addr_out),
    .ctl_wdata_in(ctl_wdata_out), .ctl_rdata_out(ctl_rdata_in));

  initial begin
    mclk_in = 1'b0;
    forever #5 mclk_in = ~mclk_in;
  end
  always @(posedge mclk_in) begin
    cyc++;
    if (ctl_rd_out === 1'b1) rd_t.push_back(cyc);
    if (ctl_wr_out === 1'b1) n_wr++;
  end
  initial begin
    #100000;
    n_errors++;
    tally_and_finish();
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [15:0] d);
    host_wr_in    <= w;
    host_rd_in    <= !w;
    host_addr_in  <= a;
    host_wdata_in <= d;
    @(posedge mclk_in);
    host_wr_in <= 1'b0;
    host_rd_in <= 1'b0;
    @(posedge mclk_in);
    if (!w) chk(host_rdata_out, d);
  endtask
  task automatic wait_lock(input logic v);
    for (int k = 0; k < 3000 && host_lock_out !== v; k++) @(posedge mclk_in);
    chk(16'(host_lock_out), 16'(v));
  endtask
  task automatic tally_and_finish();
    $display("Compared %0d, mismatched %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  initial begin
    srst_in       <= 1'b1;
    host_wr_in    <= 1'b0;
    host_rd_in    <= 1'b0;
    host_addr_in  <= 8'h00;
    host_wdata_in <= 16'h0000;
    repeat (20) @(posedge mclk_in);
    srst_in <= 1'b0;
    @(posedge mclk_in);
    for (int a = 8'h46; a < 8'h4d; a++) bus(1'b0, 8'(a), 16'h0000);
    $display("test reset values done");
    bus(1'b1, 8'h46, 16'h0104);
    bus(1'b1, 8'h47, 16'h7839);
    bus(1'b1, 8'h48, 16'h41a5);
    bus(1'b1, 8'h46, 16'h0103);
    bus(1'b1, 8'h47, 16'h3436);
    bus(1'b0, 8'h48, 16'h0000);
    bus(1'b1, 8'h48, 16'h00fa);
    bus(1'b0, 8'h47, 16'h3436);
    mdl.mem[8'h39] = 16'h1234;
    bus(1'b1, 8'h49, 16'h0103);
    wait_lock(1'b1);
    bus(1'b0, 8'h4a, 16'h0001);
    bus(1'b1, 8'h46, 16'h0000);
    wait_lock(1'b0);
    bus(1'b0, 8'h46, 16'h0103);
    bus(1'b0, 8'h49, 16'h0003);
    bus(1'b0, 8'h4b, 16'h0004);
    chk(mdl.mem[8'h36], 16'h00a0);
    chk(mdl.mem[8'h39], 16'ha534);
    chk(16'(rd_t.size()), 16'h0002);
    chk(16'(rd_t[1] - rd_t[0]), 16'(9 * TK));
    $display("test two step run done");
    for (int w = 0; w < 8; w++) begin
      bus(1'b1, 8'h46, 16'h0100);
      bus(1'b1, 8'h47, {1'b0, 3'(w), 4'(15 - w), 8'h2e});
      bus(1'b1, 8'h48, 16'h40ff);
      mdl.mem[8'h2e] = 16'h5555;
      bus(1'b1, 8'h49, 16'h0100);
      wait_lock(1'b1);
      wait_lock(1'b0);
      chk(mdl.mem[8'h2e], 16'h5555 | (16'hffff << (15 - w)));
    end
    $display("test field widths done");
    bus(1'b1, 8'h46, 16'h0105);
    bus(1'b1, 8'h47, 16'h0030);
    bus(1'b1, 8'h48, 16'h0001);
    bus(1'b1, 8'h49, 16'h0105);
    wait_lock(1'b1);
    repeat (10) @(posedge mclk_in);
    m = n_wr;
    bus(1'b1, 8'h49, 16'h0200);
    chk(16'(host_lock_out), 16'h0000);
    repeat (50) @(posedge mclk_in);
    chk(16'(n_wr - m), 16'h0000);
    bus(1'b0, 8'h49, 16'h0005);
    bus(1'b1, 8'h46, 16'h0106);
    bus(1'b0, 8'h46, 16'h0106);
    $display("test cancel done");
    bus(1'b1, 8'h46, 16'h0000);
    bus(1'b1, 8'h49, 16'h0103);
    bus(1'b0, 8'h4a, 16'h0000);
    bus(1'b1, 8'h46, 16'h0100);
    bus(1'b1, 8'h49, 16'h013b);
    bus(1'b0, 8'h49, 16'h003b);
    m = n_wr;
    bus(1'b1, 8'h49, 16'h0110);
    wait_lock(1'b1);
    wait_lock(1'b0);
    chk(16'(n_wr - m), 16'h0000);
    $display("test off, reserved and fixed steps done");
    tally_and_finish();
  end
endmodule
